// ==== pkg/sar_adc_regs.vh ====
`ifndef SAR_ADC_REGS_VH
`define SAR_ADC_REGS_VH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define OFS_CONTROL     8'h00
`define OFS_CONFIG      8'h04
`define OFS_RESULT      8'h08
`define OFS_INT_STATUS  8'h0c
`define OFS_INT_MASK    8'h10

// ------------------------------------------------------------
// converter_control_reg fields
// ------------------------------------------------------------
`define CTL_SRC_LSB     0
`define CTL_SRC_MSB     2
`define CTL_BUSY_BIT    4
`define CTL_DONE_BIT    5

// ------------------------------------------------------------
// converter_config_reg fields
// ------------------------------------------------------------
`define CFG_8BIT_BIT    1
`define CFG_JUST_BIT    2
`define CFG_DIV_LSB     3
`define CFG_DIV_MSB     7

// ------------------------------------------------------------
// interrupt status and mask fields
// ------------------------------------------------------------
`define INT_DONE_BIT    0

// ------------------------------------------------------------
// start source codes
// ------------------------------------------------------------
`define SRC_SOFTWARE    3'h0
`define SRC_TIMER0      3'h1
`define SRC_TIMER2      3'h2
`define SRC_TIMER1      3'h3
`define SRC_EXT_PIN     3'h4
`define SRC_TIMER3      3'h5

// ------------------------------------------------------------
// reset values and conversion constants
// ------------------------------------------------------------
`define RST_SRC         3'h0
`define RST_DIV         5'h1f
`define RST_BYTE        8'h00
`define CODE_MSB_IDX    4'h9
`define LSB_IDX_10BIT   4'h0
`define LSB_IDX_8BIT    4'h2
`define CODE_FIRST      10'h200
`define PAD_6           6'h00

`endif

// ==== src/sar_adc_conversion_control.v ====
// Operation
// - load result bytes at every conversion end
// - justify bit 0 right, 1 left
// - unused result bits always read zero
// - eight-bit mode converts 8 MSBs, high byte
// - eight-bit mode ignores the justify bit
// - eight-bit conversion is two SAR ticks shorter
// - SAR clock is system clock divided
// - one of six trigger sources starts conversion
// - software writes busy one to start
// - busy high throughout conversion, then cleared
// - busy fall sets done flag, interrupt
// - result valid whenever done flag is set
// - timer 2/3 low or high overflow by mode
// - external pin rising edge starts conversion
//
// The APB slave port and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "sar_adc_regs.vh"

module sar_adc_conversion_control #(
   parameter DIV_W = 5
) (
   input  wire        mclk_in,
   input  wire        srst_in,
   input  wire        psel_in,
   input  wire        penable_in,
   input  wire        pwrite_in,
   input  wire [7:0]  paddr_in,
   input  wire [31:0] pwdata_in,
   output reg  [31:0] prdata_out,
   output wire        pready_out,
   output reg         pslverr_out,
   input  wire        timer0_ovf_in,
   input  wire        timer1_ovf_in,
   input  wire        timer2_low_ovf_in,
   input  wire        timer2_high_ovf_in,
   input  wire        timer2_wide_in,
   input  wire        timer3_low_ovf_in,
   input  wire        timer3_high_ovf_in,
   input  wire        timer3_wide_in,
   input  wire        external_start_input,
   input  wire        comparator_high_in,
   output reg  [9:0]  dac_code_out,
   output reg         sample_out,
   output reg         irq_out
);

   // ------------------------------------------------------------
   // state codes
   // ------------------------------------------------------------
   localparam ST_IDLE   = 2'h0;
   localparam ST_SAMPLE = 2'h1;
   localparam ST_CONV   = 2'h2;

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   reg  [2:0]       src_q;
   reg              busy_q;
   reg              busy_prev_q;
   reg              done_q;
   reg              eight_q;
   reg              just_q;
   reg  [DIV_W-1:0] div_q;
   reg  [DIV_W-1:0] div_cnt_q;
   reg  [7:0]       res_hi_q;
   reg  [7:0]       res_lo_q;
   reg              int_stat_q;
   reg              int_mask_q;
   reg  [1:0]       state_q;
   reg  [3:0]       idx_q;
   reg              eight_run_q;
   reg              ext_s1_q;
   reg              ext_s2_q;
   reg              ext_s3_q;

   wire             wr_en;
   wire             rd_setup;
   wire             sar_tick;
   wire             ext_rise;
   reg              trigger;
   wire             sw_start;
   wire             start;
   wire             conv_end;
   wire             busy_fall;
   wire [3:0]       lsb_idx;
   wire [9:0]       final_code;
   reg  [9:0]       code_d;
   reg  [31:0]      rd_data;
   reg              rd_hit;

   // ------------------------------------------------------------
   // apb access decode
   // ------------------------------------------------------------
   assign pready_out = 1'b1;
   assign wr_en      = psel_in & penable_in & pwrite_in;
   assign rd_setup   = psel_in & ~penable_in;

   always @* begin
      rd_data = 32'h0000_0000;
      rd_hit  = 1'b1;
      case (paddr_in)
         `OFS_CONTROL: begin
            rd_data[`CTL_SRC_MSB:`CTL_SRC_LSB] = src_q;
            rd_data[`CTL_BUSY_BIT]             = busy_q;
            rd_data[`CTL_DONE_BIT]             = done_q;
         end
         `OFS_CONFIG: begin
            rd_data[`CFG_8BIT_BIT]             = eight_q;
            rd_data[`CFG_JUST_BIT]             = just_q;
            rd_data[`CFG_DIV_MSB:`CFG_DIV_LSB] = div_q;
         end
         `OFS_RESULT: begin
            rd_data[15:8] = res_hi_q;
            rd_data[7:0]  = res_lo_q;
         end
         `OFS_INT_STATUS: begin
            rd_data[`INT_DONE_BIT] = int_stat_q;
         end
         `OFS_INT_MASK: begin
            rd_data[`INT_DONE_BIT] = int_mask_q;
         end
         default: begin
            rd_hit = 1'b0;
         end
      endcase
   end

   // read data and error are captured in the setup cycle
   always @(posedge mclk_in) begin
      if (srst_in) begin
         prdata_out  <= 32'h0000_0000;
         pslverr_out <= 1'b0;
      end else if (rd_setup) begin
         prdata_out  <= pwrite_in ? 32'h0000_0000 : rd_data;
         pslverr_out <= ~rd_hit;
      end else if (~psel_in) begin
         pslverr_out <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // configuration registers
   // ------------------------------------------------------------
   always @(posedge mclk_in) begin
      if (srst_in) begin
         src_q      <= `RST_SRC;
         eight_q    <= 1'b0;
         just_q     <= 1'b0;
         div_q      <= `RST_DIV;
         int_mask_q <= 1'b0;
      end else if (wr_en) begin
         if (paddr_in == `OFS_CONTROL) begin
            src_q <= pwdata_in[`CTL_SRC_MSB:`CTL_SRC_LSB];
         end
         if (paddr_in == `OFS_CONFIG) begin
            eight_q <= pwdata_in[`CFG_8BIT_BIT];
            just_q  <= pwdata_in[`CFG_JUST_BIT];
            div_q   <= pwdata_in[`CFG_DIV_MSB:`CFG_DIV_LSB];
         end
         if (paddr_in == `OFS_INT_MASK) begin
            int_mask_q <= pwdata_in[`INT_DONE_BIT];
         end
      end
   end

   // ------------------------------------------------------------
   // sar clock divider
   // ------------------------------------------------------------
   // divide by field plus one
   assign sar_tick = (div_cnt_q == div_q);

   always @(posedge mclk_in) begin
      if (srst_in) begin
         div_cnt_q <= {DIV_W{1'b0}};
      end else if (sar_tick || state_q == ST_IDLE) begin
         div_cnt_q <= {DIV_W{1'b0}};
      end else begin
         div_cnt_q <= div_cnt_q + {{(DIV_W-1){1'b0}}, 1'b1};
      end
   end

   // ------------------------------------------------------------
   // trigger selection
   // ------------------------------------------------------------
   // synchronise start pin, detect rise
   always @(posedge mclk_in) begin
      if (srst_in) begin
         ext_s1_q <= 1'b0;
         ext_s2_q <= 1'b0;
         ext_s3_q <= 1'b0;
      end else begin
         ext_s1_q <= external_start_input;
         ext_s2_q <= ext_s1_q;
         ext_s3_q <= ext_s2_q;
      end
   end

   assign ext_rise = ext_s2_q & ~ext_s3_q;

   // busy written one in software mode
   assign sw_start = wr_en && (paddr_in == `OFS_CONTROL) &&
                     pwdata_in[`CTL_BUSY_BIT] && (src_q == `SRC_SOFTWARE);

   always @* begin
      case (src_q)
         `SRC_SOFTWARE: trigger = sw_start;
         `SRC_TIMER0:   trigger = timer0_ovf_in;
         `SRC_TIMER2:   trigger = timer2_wide_in ? timer2_high_ovf_in : timer2_low_ovf_in;
         `SRC_TIMER1:   trigger = timer1_ovf_in;
         `SRC_EXT_PIN:  trigger = ext_rise;
         `SRC_TIMER3:   trigger = timer3_wide_in ? timer3_high_ovf_in : timer3_low_ovf_in;
         default:       trigger = 1'b0;
      endcase
   end

   // triggers arriving while busy are dropped
   assign start = trigger & ~busy_q;

   // ------------------------------------------------------------
   // successive approximation sequencer
   // ------------------------------------------------------------
   // eight-bit run stops two bits early
   assign lsb_idx  = eight_run_q ? `LSB_IDX_8BIT : `LSB_IDX_10BIT;
   assign conv_end = (state_q == ST_CONV) && sar_tick && (idx_q == lsb_idx);

   always @* begin
      code_d = dac_code_out;
      if (~comparator_high_in) begin
         code_d[idx_q] = 1'b0;
      end
      if (idx_q != lsb_idx) begin
         code_d[idx_q - 4'h1] = 1'b1;
      end
   end

   assign final_code = code_d;

   always @(posedge mclk_in) begin
      if (srst_in) begin
         state_q      <= ST_IDLE;
         busy_q       <= 1'b0;
         idx_q        <= `CODE_MSB_IDX;
         eight_run_q  <= 1'b0;
         dac_code_out <= 10'h000;
         sample_out   <= 1'b0;
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (start) begin
                  state_q     <= ST_SAMPLE;
                  busy_q      <= 1'b1;
                  sample_out  <= 1'b1;
                  eight_run_q <= eight_q;
               end
            end
            ST_SAMPLE: begin
               if (sar_tick) begin
                  state_q      <= ST_CONV;
                  sample_out   <= 1'b0;
                  idx_q        <= `CODE_MSB_IDX;
                  dac_code_out <= `CODE_FIRST;
               end
            end
            ST_CONV: begin
               if (sar_tick) begin
                  dac_code_out <= code_d;
                  if (idx_q == lsb_idx) begin
                     state_q <= ST_IDLE;
                     busy_q  <= 1'b0;
                  end else begin
                     idx_q <= idx_q - 4'h1;
                  end
               end
            end
            default: begin
               state_q    <= ST_IDLE;
               busy_q     <= 1'b0;
               sample_out <= 1'b0;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // result formatting
   // ------------------------------------------------------------
   // load both bytes at conversion end
   always @(posedge mclk_in) begin
      if (srst_in) begin
         res_hi_q <= `RST_BYTE;
         res_lo_q <= `RST_BYTE;
      end else if (conv_end) begin
         if (eight_run_q) begin
            res_hi_q <= final_code[9:2];
            res_lo_q <= `RST_BYTE;
         // left justified when bit is one
         end else if (just_q) begin
            res_hi_q <= final_code[9:2];
            res_lo_q <= {final_code[1:0], `PAD_6};
         end else begin
            res_hi_q <= {`PAD_6, final_code[9:8]};
            res_lo_q <= final_code[7:0];
         end
      end
   end

   // ------------------------------------------------------------
   // completion flag and interrupt
   // ------------------------------------------------------------
   always @(posedge mclk_in) begin
      if (srst_in) begin
         busy_prev_q <= 1'b0;
      end else begin
         busy_prev_q <= busy_q;
      end
   end

   assign busy_fall = busy_prev_q & ~busy_q;

   // busy fall sets done and status
   always @(posedge mclk_in) begin
      if (srst_in) begin
         done_q     <= 1'b0;
         int_stat_q <= 1'b0;
         irq_out    <= 1'b0;
      end else begin
         if (busy_fall) begin
            done_q <= 1'b1;
         end else if (wr_en && paddr_in == `OFS_CONTROL && ~pwdata_in[`CTL_DONE_BIT]) begin
            done_q <= 1'b0;
         end
         if (busy_fall) begin
            int_stat_q <= 1'b1;
         end else if (wr_en && paddr_in == `OFS_INT_STATUS && pwdata_in[`INT_DONE_BIT]) begin
            int_stat_q <= 1'b0;
         end
         irq_out <= int_stat_q & int_mask_q;
      end
   end

endmodule

`default_nettype wire

// ==== testbench/sar_adc_conversion_control_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "sar_adc_regs.vh"
module sar_adc_props (
   input  wire logic        mclk_in,
   input  wire logic        srst_in,
   input  wire logic        psel_in,
   input  wire logic        penable_in,
   input  wire logic        pwrite_in,
   input  wire logic [7:0]  paddr_in,
   input  wire logic [31:0] pwdata_in,
   input  wire logic [31:0] prdata_out,
   input  wire logic        pready_out,
   input  wire logic        pslverr_out,
   input  wire logic [9:0]  dac_code_out,
   input  wire logic        sample_out,
   input  wire logic        irq_out
);
   default clocking @(posedge mclk_in); endclocking
   default disable iff (srst_in);
   wire       acc_w = psel_in && penable_in;
   wire       wr_w  = acc_w && pwrite_in;
   wire       map_w = paddr_in[1:0] == 2'h0 && paddr_in <= `OFS_INT_MASK;
   logic [2:0] src_q;
   logic [4:0] div_q;
   logic       mask_q;
   always @(posedge mclk_in) begin
      if (srst_in) begin
         src_q  <= 3'h0;
         div_q  <= 5'h1f;
         mask_q <= 1'b0;
      end else if (wr_w) begin
         if (paddr_in == `OFS_CONTROL) src_q <= pwdata_in[2:0];
         if (paddr_in == `OFS_CONFIG) div_q <= pwdata_in[7:3];
         if (paddr_in == `OFS_INT_MASK) mask_q <= pwdata_in[0];
      end
   end
   sequence one_tick;
      sample_out ##1 !sample_out;
   endsequence
   sequence mask_off;
      wr_w && paddr_in == `OFS_INT_MASK && !pwdata_in[0];
   endsequence
   pready_high_a: assert property (pready_out) else $error("pready low");
   unmapped_err_a: assert property (acc_w && !map_w |-> pslverr_out) else $error("no slverr");
   mapped_ok_a: assert property (acc_w && map_w |-> !pslverr_out) else $error("bad slverr");
   result_pad_a: assert property (acc_w && !pwrite_in && paddr_in == `OFS_RESULT |->
      prdata_out[31:16] == 16'h0000) else $error("result pad set");
   reserved_src_a: assert property (src_q > 3'h5 && src_q == $past(src_q)
      |-> !$rose(sample_out)) else $error("reserved source started");
   first_trial_a: assert property ($fell(sample_out) |-> dac_code_out == `CODE_FIRST)
      else $error("first trial code wrong");
   sample_tick_a: assert property ($rose(sample_out) && div_q == 5'h00 |-> one_tick)
      else $error("sample not one tick");
   irq_masked_a: assert property ($rose(irq_out) |-> $past(mask_q))
      else $error("irq while masked");
   mask_drop_a: assert property (mask_off |-> ##2 !irq_out) else $error("irq stayed");
   reset_clear_a: assert property ($fell(srst_in) |-> !irq_out && !sample_out && !pslverr_out
      && dac_code_out == 10'h000) else $error("reset state wrong");
endmodule
bind sar_adc_conversion_control sar_adc_props u_props (.mclk_in(mclk_in), .srst_in(srst_in),
   .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
   .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
   .pslverr_out(pslverr_out), .dac_code_out(dac_code_out), .sample_out(sample_out),
   .irq_out(irq_out));
`default_nettype wire

// ==== testbench/test_sar_adc_conversion_control.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "sar_adc_regs.vh"
module test_sar_adc_conversion_control;
   logic        mclk_in = 0, srst_in = 1, psel = 0, penable = 0, pwrite = 0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd_q;
   logic        pready, pslverr, t0, t1, t2l, t2h, t3l, t3h, pin, cmp, irq, smp;
   logic        go = 0, wide = 0, decoy = 0, mask = 0, err, irq_prev = 0;
   logic [2:0]  src = 3'h0;
   logic [9:0]  target = 10'h000, dac;
   integer      failures = 0, compares = 0, seed = 32'h28c97b54, cyc = 0, t_irq = 0;
   integer      last, l10, i, q [$];
   always #12.5 mclk_in = ~mclk_in;
   always @(posedge mclk_in) begin
      cyc <= cyc + 1;
      irq_prev <= irq;
      if (irq === 1'b1 && irq_prev !== 1'b1) t_irq <= cyc;
   end
   sar_adc_conversion_control uut (.mclk_in(mclk_in), .srst_in(srst_in), .psel_in(psel),
      .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
      .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .timer0_ovf_in(t0),
      .timer1_ovf_in(t1), .timer2_low_ovf_in(t2l), .timer2_high_ovf_in(t2h),
      .timer2_wide_in(wide), .timer3_low_ovf_in(t3l), .timer3_high_ovf_in(t3h),
      .timer3_wide_in(wide), .external_start_input(pin), .comparator_high_in(cmp),
      .dac_code_out(dac), .sample_out(smp), .irq_out(irq));
   timer_pin_model far (.mclk_in(mclk_in), .go_in(go), .src_in(src), .wide_in(wide ^ decoy),
      .target_in(target), .dac_code_in(dac), .t0_out(t0), .t1_out(t1), .t2l_out(t2l),
      .t2h_out(t2h), .t3l_out(t3l), .t3h_out(t3h), .pin_out(pin), .cmp_out(cmp));
   task wrap_up;
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task chk(input string n, input logic [31:0] e, input logic [31:0] s);
      compares++;
      if (s !== e) begin
         failures++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk_in);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
      @(posedge mclk_in);
      penable <= 1;
      @(posedge mclk_in);
      while (pready !== 1'b1) @(posedge mclk_in);
      rd_q = prdata;
      err = pslverr;
      {psel, penable} <= 2'b00;
   endtask
   task rd(input string n, input logic [7:0] a, input logic [31:0] e);
      apb(0, a, 32'h0);
      chk(n, e, rd_q);
   endtask
   task pulse(input logic [2:0] s);
      src <= s;
      go <= 1;
      @(posedge mclk_in);
      go <= 0;
      repeat (6) @(posedge mclk_in);
   endtask
   function automatic logic [31:0] fmt(input logic [9:0] t, input logic m8, lj);
      if (m8) return {16'h0, t[9:2], 8'h00};
      return lj ? {16'h0, t, 6'h00} : {22'h0, t};
   endfunction
   task conv(input logic [2:0] s, input logic m8, lj, input logic [4:0] dv, input logic [9:0] t);
      integer t0, n;
      target <= t;
      apb(1, `OFS_CONFIG, {24'h0, dv, lj, m8, 1'b0});
      apb(1, `OFS_CONTROL, {29'h0, s});
      q.push_back(fmt(t, m8, lj));
      if (s == `SRC_TIMER2 || s == `SRC_TIMER3) begin
         decoy <= 1;
         pulse(s);
         rd("decoy", `OFS_CONTROL, {29'h0, s});
         decoy <= 0;
      end
      t0 = cyc;
      if (s == `SRC_SOFTWARE) apb(1, `OFS_CONTROL, 32'h10);
      else pulse(s);
      rd("busy", `OFS_CONTROL, 32'h10 | s);
      n = 0;
      do begin
         apb(0, `OFS_CONTROL, 32'h0);
         n++;
      end while (rd_q[5] !== 1'b1 && n < 200);
      chk("done", 32'h20 | s, rd_q);
      rd("result", `OFS_RESULT, q.pop_front());
      last = t_irq - t0;
      chk("irq", mask, irq);
      rd("status", `OFS_INT_STATUS, 32'h1);
      apb(1, `OFS_CONTROL, 32'h20 | s);
      rd("done kept", `OFS_CONTROL, 32'h20 | s);
      apb(1, `OFS_CONTROL, {29'h0, s});
      apb(1, `OFS_INT_STATUS, 32'h1);
      rd("cleared", `OFS_CONTROL, {29'h0, s});
      chk("irq off", 0, irq);
   endtask
   initial begin
      repeat (40000) @(posedge mclk_in);
      failures++;
      wrap_up;
   end
   initial begin
      repeat (4) @(posedge mclk_in);
      srst_in <= 0;
      rd("config", `OFS_CONFIG, 32'hf8);
      rd("control", `OFS_CONTROL, 32'h0);
      rd("result", `OFS_RESULT, 32'h0);
      rd("unmapped", 8'h14, 32'h0);
      chk("slverr", 1, err);
      $display("test reset done");
      conv(`SRC_SOFTWARE, 0, 0, 0, 10'h3ff);
      conv(`SRC_SOFTWARE, 0, 1, 0, 10'h3ff);
      conv(`SRC_SOFTWARE, 0, 1, 0, 10'h200);
      conv(`SRC_SOFTWARE, 1, 1, 0, 10'h3ff);
      mask <= 1;
      apb(1, `OFS_INT_MASK, 32'h1);
      for (i = 0; i < 12; i++) begin
         wide <= i[0];
         conv(i[3:1], $random(seed), $random(seed), 0, $random(seed));
      end
      $display("test sources done");
      for (i = 6; i < 8; i++) begin
         apb(1, `OFS_CONTROL, i);
         pulse(i);
         rd("reserved", `OFS_CONTROL, i);
      end
      for (i = 0; i < 3; i++) begin
         conv(`SRC_SOFTWARE, 0, 0, i, $random(seed));
         l10 = last;
         chk("sar clock", 1, l10 >= 11 * (i + 1));
         conv(`SRC_SOFTWARE, 1, 0, i, $random(seed));
         chk("shorter", 1, l10 - last == 2 * (i + 1));
      end
      apb(1, `OFS_CONTROL, 32'h10);
      repeat (60) @(posedge mclk_in);
      chk("irq on", 1, irq);
      mask <= 0;
      apb(1, `OFS_INT_MASK, 32'h0);
      rd("status kept", `OFS_INT_STATUS, 32'h1);
      rd("done stays", `OFS_CONTROL, 32'h20);
      chk("irq masked", 0, irq);
      $display("test timing done");
      wrap_up;
   end
endmodule
`default_nettype wire

// ==== testbench/timer_pin_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------
// timers, start pin and comparator
// ------------------------------------
module timer_pin_model (
   input  wire logic       mclk_in,
   input  wire logic       go_in,
   input  wire logic [2:0] src_in,
   input  wire logic       wide_in,
   input  wire logic [9:0] target_in,
   input  wire logic [9:0] dac_code_in,
   output var  logic       t0_out,
   output var  logic       t1_out,
   output var  logic       t2l_out,
   output var  logic       t2h_out,
   output var  logic       t3l_out,
   output var  logic       t3h_out,
   output wire logic       pin_out,
   output wire logic       cmp_out
);
   logic [2:0] hold_q = 3'h0;
   wire        all_w   = src_in > 3'h5;
   initial {t0_out, t1_out, t2l_out, t2h_out, t3l_out, t3h_out} = 6'h00;
   always @(posedge mclk_in) begin
      t0_out  <= go_in && (src_in == 3'h1 || all_w);
      t1_out  <= go_in && (src_in == 3'h3 || all_w);
      t2l_out <= go_in && ((src_in == 3'h2 && !wide_in) || all_w);
      t2h_out <= go_in && ((src_in == 3'h2 && wide_in) || all_w);
      t3l_out <= go_in && ((src_in == 3'h5 && !wide_in) || all_w);
      t3h_out <= go_in && ((src_in == 3'h5 && wide_in) || all_w);
      if (go_in && (src_in == 3'h4 || all_w)) hold_q <= 3'h4;
      else if (hold_q != 3'h0) hold_q <= hold_q - 3'h1;
   end
   assign pin_out = hold_q != 3'h0;
   assign cmp_out = target_in >= dac_code_in;
endmodule
`default_nettype wire
